// ### src/sdprb_addr_gen.sv
// Purpose: picks the array addresses for each mode and keeps fifo fill
// Assumes: captures arrive as one-cycle strobes on ref_clk
// Notes: pointers are not rewound when the shape changes
`timescale 1ns/1ps
`default_nettype none
module sdprb_addr_gen #(
  parameter int AW = sdprb_pkg::ADDR_W,
  parameter int CW = sdprb_pkg::CNT_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // setup and strobes
  input wire sdprb_pkg::sdprb_mode_t mode,
  input wire sdprb_pkg::sdprb_shape_t shape,
  input wire logic wr_cap,
  input wire logic rd_cap,
  input wire logic [AW-1:0] usr_waddr,
  input wire logic [AW-1:0] usr_raddr,
  // results
  output logic [AW-1:0] waddr,
  output logic [AW-1:0] raddr,
  output logic wr_ok,
  output logic rd_ok,
  output logic [CW-1:0] fill,
  output logic full,
  output logic empty
);
  localparam logic [CW-1:0] ONE = CW'(1);
  logic [AW-1:0] wptr_reg, rptr_reg;
  logic [CW-1:0] fill_reg;
  wire logic [CW-1:0] depth = sdprb_pkg::shape_depth(shape);
  wire logic is_fifo = mode == sdprb_pkg::MD_FIFO;
  wire logic is_shift = mode == sdprb_pkg::MD_SHIFT;
  // pointers stay put in addressed modes so a later fifo starts aligned
  wire logic wr_step = wr_cap && wr_ok && (is_fifo || is_shift); // [RQ3]
  wire logic rd_step = rd_cap && rd_ok && is_fifo;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p, input logic [CW-1:0] d);
    bump = ({1'b0, p} == d - ONE) ? '0 : p + 1'b1;
  endfunction

  // rom refuses writes, fifo refuses overrun and underrun [RQ3]
  assign full = fill_reg == depth;
  assign empty = fill_reg == '0;
  assign fill = fill_reg;
  assign wr_ok = mode != sdprb_pkg::MD_ROM && !(is_fifo && full);
  assign rd_ok = !(is_fifo && empty);
  assign waddr = (is_fifo || is_shift) ? wptr_reg : usr_waddr;
  // shift register reads the oldest entry, the one about to be overwritten
  assign raddr = is_fifo ? rptr_reg : (is_shift ? wptr_reg :
                 (mode == sdprb_pkg::MD_SP ? usr_waddr : usr_raddr));

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      fill_reg <= '0;
    end else begin
      if (wr_step) wptr_reg <= bump(wptr_reg, depth);
      if (rd_step) rptr_reg <= bump(rptr_reg, depth);
      if (is_fifo && wr_step != rd_step) fill_reg <= wr_step ? fill_reg + ONE : fill_reg - ONE;
    end
  end
endmodule
`default_nettype wire

// ### src/sdprb_axil.sv
// Purpose: axi4-lite slave holding the control word and showing status
// Assumes: one write and one read in flight at most
// Notes: unmapped addresses answer slverr; status writes are ignored
`timescale 1ns/1ps
`default_nettype none
module sdprb_axil (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // write channels
  input wire logic [sdprb_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [sdprb_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register view
  output logic [31:0] ctrl_reg,
  input wire logic [31:0] status
);
  logic [sdprb_pkg::AXI_AW-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [31:0] ctrl_next;
  wire logic wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire logic wr_ctrl = aw_addr_reg == sdprb_pkg::CTRL_OFF;
  wire logic wr_map = wr_ctrl || aw_addr_reg == sdprb_pkg::STAT_OFF;
  wire logic rd_ctrl = s_axi_araddr == sdprb_pkg::CTRL_OFF;
  wire logic rd_stat = s_axi_araddr == sdprb_pkg::STAT_OFF;
  wire logic [31:0] rd_mux = rd_ctrl ? ctrl_reg : (rd_stat ? status : 32'h0);

  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign ctrl_next[8*i +: 8] = w_strb_reg[i] ? w_data_reg[8*i +: 8] : ctrl_reg[8*i +: 8];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sdprb_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= sdprb_pkg::RESP_OKAY;
      ctrl_reg <= sdprb_pkg::CTRL_RST;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? sdprb_pkg::RESP_OKAY : sdprb_pkg::RESP_SLVERR;
        if (wr_ctrl) ctrl_reg <= ctrl_next;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= (rd_ctrl || rd_stat) ? sdprb_pkg::RESP_OKAY : sdprb_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### src/sdprb_pkg.sv
// Purpose: shared constants, types and shape decode for the small ram block
// Assumes: one system clock; software sets the block up over axi4-lite
// Notes: the bus slave and the core share the register map defined here
package sdprb_pkg;
  localparam int TOTAL_BITS = 576;
  localparam int MAX_W = 18;
  localparam int ADDR_W = 9;
  localparam int CNT_W = 10;
  localparam int WID_W = 5;
  localparam int MODE_W = 3;
  localparam int SHAPE_W = 3;
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] CTRL_OFF = 4'h0;
  localparam logic [AXI_AW-1:0] STAT_OFF = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_SHAPE_LSB = 4;
  localparam int CTL_WSEL_BIT = 8;
  localparam int CTL_RSEL_BIT = 9;
  localparam int CTL_OSEL_BIT = 10;
  localparam int CTL_BYP_BIT = 11;
  localparam int STAT_FULL_BIT = 16;
  localparam int STAT_EMPTY_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [MODE_W-1:0] {MD_SDP, MD_SP, MD_FIFO, MD_ROM, MD_SHIFT} sdprb_mode_t;
  typedef enum logic [SHAPE_W-1:0] {
    SH_512X1, SH_256X2, SH_128X4, SH_64X8, SH_64X9, SH_32X16, SH_32X18
  } sdprb_shape_t;

  function automatic logic [WID_W-1:0] shape_width(input sdprb_shape_t s);
    case (s)
      SH_512X1: shape_width = 5'h01;
      SH_256X2: shape_width = 5'h02;
      SH_128X4: shape_width = 5'h04;
      SH_64X8: shape_width = 5'h08;
      SH_64X9: shape_width = 5'h09;
      SH_32X16: shape_width = 5'h10;
      default: shape_width = 5'h12;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] shape_depth(input sdprb_shape_t s);
    case (s)
      SH_512X1: shape_depth = 10'h200;
      SH_256X2: shape_depth = 10'h100;
      SH_128X4: shape_depth = 10'h080;
      SH_64X8, SH_64X9: shape_depth = 10'h040;
      default: shape_depth = 10'h020;
    endcase
  endfunction
endpackage

// ### src/sdprb_ram.sv
// Purpose: small simple dual-port ram block with selectable shape and mode
// Assumes: block clocks arrive as enable pulses on ref_clk
// Notes: the array is flip-flops; reset reloads the initial image
//
// How it works
// RQ1 - separate write and read ports, each with its own address
// RQ2 - array holds 576 bits, parity bits included
// RQ3 - modes: simple dual-port, single-port, fifo, rom, shift register
// RQ4 - shapes 512x1 to 32x18; 9 and 18 bit shapes use parity bits
// RQ5 - ram and rom contents load from an initial image
// RQ6 - write enable, data and address registers share one selected clock
// RQ7 - read address, read enable and output registers take either clock
// RQ8 - read/write or input/output clock arrangements both possible
// RQ9 - output register may be bypassed; input registers always used
// RQ10 - input clear resets the input registers at once
// RQ11 - after input clear the output changes only at the next edge
// RQ12 - output clear zeroes the output registers at once
// RQ13 - user logic supplies clocks, enables, clock enables and clears
// RQ14 - output registers are zero after power-up
// RQ15 - read of the address being written returns old contents
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module sdprb_ram #(
  parameter int AW = sdprb_pkg::ADDR_W,
  parameter int DW = sdprb_pkg::MAX_W,
  parameter int TB = sdprb_pkg::TOTAL_BITS,
  parameter logic [sdprb_pkg::TOTAL_BITS-1:0] INIT_IMAGE = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,

  // axi4-lite write
  input wire logic [sdprb_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,

  // axi4-lite read
  input wire logic [sdprb_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,

  // the two block clocks as enable pulses, and their clock enables
  input wire logic [1:0] blk_tick,
  input wire logic [1:0] blk_clk_en,

  // asynchronous clears, active high
  input wire logic in_clr,
  input wire logic out_clr,

  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,

  // read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // setup decode

  logic [31:0] ctrl_reg;
  logic [31:0] status;
  sdprb_pkg::sdprb_mode_t mode;
  sdprb_pkg::sdprb_shape_t shape;
  logic [sdprb_pkg::WID_W-1:0] word_w;

  assign mode = sdprb_pkg::sdprb_mode_t'(ctrl_reg[sdprb_pkg::CTL_MODE_LSB +: sdprb_pkg::MODE_W]);
  assign shape = sdprb_pkg::sdprb_shape_t'(
                 ctrl_reg[sdprb_pkg::CTL_SHAPE_LSB +: sdprb_pkg::SHAPE_W]);
  assign word_w = sdprb_pkg::shape_width(shape); // [RQ4]

  wire logic wr_sel = ctrl_reg[sdprb_pkg::CTL_WSEL_BIT];
  wire logic rd_sel = ctrl_reg[sdprb_pkg::CTL_RSEL_BIT];
  wire logic out_sel = ctrl_reg[sdprb_pkg::CTL_OSEL_BIT];
  wire logic bypass = ctrl_reg[sdprb_pkg::CTL_BYP_BIT];

  // one clock for the whole write side, free choice for read and output
  wire logic wr_tick = blk_tick[wr_sel] && blk_clk_en[wr_sel]; // [RQ6] [RQ13]
  wire logic rd_tick = blk_tick[rd_sel] && blk_clk_en[rd_sel]; // [RQ7] [RQ8]
  wire logic out_tick = blk_tick[out_sel] && blk_clk_en[out_sel]; // [RQ7] [RQ8]

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  sdprb_axil u_axil (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .ctrl_reg(ctrl_reg),
    .status(status)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode dependent addressing

  logic [AW-1:0] ag_waddr, ag_raddr;
  logic ag_wr_ok, ag_rd_ok, ag_full, ag_empty;
  logic [sdprb_pkg::CNT_W-1:0] ag_fill;

  sdprb_addr_gen u_addr_gen (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .mode(mode),
    .shape(shape),
    .wr_cap(wr_tick && wr_en),
    .rd_cap(rd_tick && rd_en),
    .usr_waddr(wr_addr),
    .usr_raddr(rd_addr),
    .waddr(ag_waddr),
    .raddr(ag_raddr),
    .wr_ok(ag_wr_ok),
    .rd_ok(ag_rd_ok),
    .fill(ag_fill),
    .full(ag_full),
    .empty(ag_empty)
  );

  always_comb begin
    status = 32'h0;
    status[sdprb_pkg::CNT_W-1:0] = ag_fill;
    status[sdprb_pkg::STAT_FULL_BIT] = ag_full;
    status[sdprb_pkg::STAT_EMPTY_BIT] = ag_empty;
  end

  ////////////////////////////////////////////////////////////////////////////
  // input registers, cleared without a clock

  logic wr_go_reg, rd_en_reg;
  logic [AW-1:0] wr_addr_reg, rd_addr_reg;
  logic [DW-1:0] wr_data_reg;

  // write enable is kept as a one-cycle commit so each edge writes once
  always_ff @(posedge ref_clk or posedge in_clr) begin
    if (in_clr) begin // [RQ10]
      wr_go_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else if (!resetn) begin
      wr_go_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      wr_go_reg <= wr_tick && wr_en && ag_wr_ok; // [RQ6] [RQ3]
      if (wr_tick) begin // [RQ6]
        wr_addr_reg <= ag_waddr;
        wr_data_reg <= wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge in_clr) begin
    if (in_clr) begin // [RQ10]
      rd_en_reg <= 1'b0;
      rd_addr_reg <= '0;
    end else if (!resetn) begin
      rd_en_reg <= 1'b0;
      rd_addr_reg <= '0;
    end else if (rd_tick) begin // [RQ7] [RQ1]
      rd_en_reg <= rd_en && ag_rd_ok;
      rd_addr_reg <= ag_raddr;
    end
  end

  // bypass path looks through this copy, so a clear shows one edge late
  logic [AW-1:0] sh_addr_reg;

  always_ff @(posedge ref_clk) begin
    if (!resetn) sh_addr_reg <= '0;
    else sh_addr_reg <= rd_addr_reg; // [RQ11]
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage array

  logic [TB-1:0] mem_reg, mem_next;
  int wbase;

  // bits past the end of the 576-bit array fall off and are dropped, whatever the chosen depth
  function automatic logic [DW-1:0] read_word(input logic [TB-1:0] m,
                                              input logic [AW-1:0] a,
                                              input logic [sdprb_pkg::WID_W-1:0] w);
    int base;
    base = int'(a) * int'(w);
    read_word = '0;
    for (int j = 0; j < DW; j++) begin
      if (j < int'(w) && base + j < TB) read_word[j] = m[base + j];
    end
  endfunction

  assign wbase = int'(wr_addr_reg) * int'(word_w);

  always_comb begin
    mem_next = mem_reg;
    for (int j = 0; j < DW; j++) begin
      if (wr_go_reg && j < int'(word_w) && wbase + j < TB) begin // [RQ4] [RQ2]
        mem_next[wbase + j] = wr_data_reg[j];
      end
    end
  end

  // reset reloads the image, which is how rom contents get in
  always_ff @(posedge ref_clk) begin
    if (!resetn) mem_reg <= INIT_IMAGE; // [RQ5]
    else mem_reg <= mem_next; // [RQ2]
  end

  wire logic [DW-1:0] out_word = read_word(mem_reg, rd_addr_reg, word_w);
  wire logic [DW-1:0] byp_word = read_word(mem_reg, sh_addr_reg, word_w);

  ////////////////////////////////////////////////////////////////////////////
  // output register

  logic [DW-1:0] out_reg;

  // array still holds the old word while a same-edge write commits
  always_ff @(posedge ref_clk or posedge out_clr) begin
    if (out_clr) out_reg <= '0; // [RQ12]
    else if (!resetn) out_reg <= '0; // [RQ14]
    else if (out_tick && rd_en_reg) out_reg <= out_word; // [RQ7] [RQ15]
  end

  // bypass trades the output register for combinational read data
  assign rd_data = bypass ? byp_word : out_reg; // [RQ9]

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking ac @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_old_addr_shown;
    sh_addr_reg == $past(rd_addr_reg);
  endsequence

  sequence s_clear_shown;
    ##1 (sh_addr_reg == '0 || !in_clr);
  endsequence

  chk_in_clear_now: assert property (in_clr |-> !wr_go_reg && !rd_en_reg && rd_addr_reg == '0) // [RQ10]
    else $error("input registers not cleared by in_clr");

  chk_in_clear_lag: assert property ($rose(in_clr) |-> s_old_addr_shown and s_clear_shown) // [RQ11]
    else $error("bypass path saw input clear at the wrong edge");

  chk_out_clear_now: assert property (out_clr |-> out_reg == '0) // [RQ12]
    else $error("output register not cleared by out_clr");

  chk_power_up_zero: assert property ($rose(resetn) |-> out_reg == '0) // [RQ14]
    else $error("output register not zero after reset");

  chk_old_data_read: assert property (out_tick && rd_en_reg && wr_go_reg && // [RQ15]
      wr_addr_reg == rd_addr_reg && !out_clr |=> out_clr ||
      out_reg == $past(read_word(mem_reg, rd_addr_reg, word_w)))
    else $error("read during write did not return old data");

  chk_write_capture: assert property (wr_tick && wr_en && ag_wr_ok && !in_clr |=> // [RQ6]
      in_clr || (wr_go_reg && wr_data_reg == $past(wr_data) && wr_addr_reg == $past(ag_waddr)))
    else $error("write side registers did not capture together");

  chk_read_hold: assert property (!rd_tick |=> in_clr || $stable(rd_addr_reg)) // [RQ7]
    else $error("read address moved without its clock");

  chk_out_own_clock: assert property (!(out_tick && rd_en_reg) |=> out_clr || $stable(out_reg)) // [RQ8]
    else $error("output register moved without its clock");

  chk_ports_apart: assert property (mode == sdprb_pkg::MD_SDP && rd_tick && !in_clr |=> // [RQ1]
      in_clr || rd_addr_reg == $past(rd_addr))
    else $error("read port did not use its own address");

  chk_rom_no_write: assert property (mode == sdprb_pkg::MD_ROM |=> !wr_go_reg) // [RQ3]
    else $error("rom mode committed a write");

  chk_bypass_path: assert property (rd_data == // [RQ9]
      (bypass ? read_word(mem_reg, $past(rd_addr_reg), word_w) : out_reg))
    else $error("read data not from selected path");

  chk_shape_width: assert property ((out_word >> word_w) == '0) // [RQ4]
    else $error("read word wider than the shape");

endmodule
`default_nettype wire

// ### verification/sdprb_fabric.sv
// Purpose: fabric-side user logic that drives the ram block ports
// Assumes: the bench paces the two block clocks and their enables
// Notes: released address and data lines flip so a stale value never matches
`timescale 1ns/1ps
`default_nettype none
module sdprb_fabric (
  // clock
  input wire logic ref_clk,
  // pacing from the bench
  input wire logic slow,
  input wire logic [1:0] tick_on,
  input wire logic [1:0] cen,
  // block clocks and enables
  output logic [1:0] blk_tick,
  output logic [1:0] blk_clk_en,
  // memory ports
  output logic wr_en,
  output logic [sdprb_pkg::ADDR_W-1:0] wr_addr,
  output logic [sdprb_pkg::MAX_W-1:0] wr_data,
  output logic rd_en,
  output logic [sdprb_pkg::ADDR_W-1:0] rd_addr
);
  logic [1:0] phase = 2'h0;
  logic pace = 1'b1;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_addr = 9'h000;
    wr_data = 18'h00000;
    rd_addr = 9'h000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // ticks follow tick_on at once, so the bench can stop a clock mid-transfer
  always @(posedge ref_clk) begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    pace <= !slow || phase == 2'h2;
  end
  assign blk_tick = tick_on & {2{pace}};
  assign blk_clk_en = cen;
  ////////////////////////////////////////////////////////////////////////////////
  // slow pacing holds four cycles so at least one tick lands inside
  task automatic access(input logic we, input logic [8:0] wa, input logic [17:0] wd,
      input logic re, input logic [8:0] ra);
    @(posedge ref_clk);
    wr_en <= we;
    wr_addr <= wa;
    wr_data <= wd;
    rd_en <= re;
    rd_addr <= ra;
    repeat (slow ? 4 : 1) @(posedge ref_clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    wr_addr <= ~wa;
    wr_data <= ~wd;
    rd_addr <= ~ra;
  endtask
endmodule
`default_nettype wire

// ### verification/sdprb_ram_tb.sv
// Purpose: self-checking bench for the small ram block
// Assumes: fabric model paces block clocks; registers over axi4-lite
// Notes: expectations come from the shape table, the initial image and written patterns
`timescale 1ns/1ps
`default_nettype none
module sdprb_ram_tb;
  localparam logic [575:0] IMG = {558'h0, 18'h2c3c3};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [1:0] blk_tick;
  logic [1:0] blk_clk_en;
  logic in_clr = 1'b0;
  logic out_clr = 1'b0;
  logic slow = 1'b0;
  logic [1:0] tick_on = 2'h3;
  logic [1:0] cen = 2'h3;
  logic wr_en;
  logic rd_en;
  logic [8:0] wr_addr;
  logic [8:0] rd_addr;
  logic [17:0] wr_data;
  logic [17:0] rd_data;
  logic [31:0] d;
  logic [1:0] r;
  int bad_count = 0;
  int total_checks = 0;
  int dep[7] = '{512, 256, 128, 64, 64, 32, 32};
  int wid[7] = '{1, 2, 4, 8, 9, 16, 18};

  sdprb_ram #(.INIT_IMAGE(IMG)) u_sdprb_ram (.ref_clk, .resetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .blk_tick, .blk_clk_en, .in_clr, .out_clr,
    .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr, .rd_data);
  sdprb_fabric u_sdprb_fabric (.ref_clk, .slow, .tick_on, .cen, .blk_tick, .blk_clk_en,
    .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr);

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 50) begin
      bad_count++;
      end_sim();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // bus tasks wait for the answer, never a fixed count
  task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 50) begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 50) begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  // sel is {bypass, output clock, read clock, write clock}
  function automatic logic [31:0] ctl(input logic [2:0] md, input logic [2:0] sh,
      input logic [3:0] sel);
    ctl = {20'h0, sel, 1'b0, sh, 1'b0, md};
  endfunction
  task automatic setc(input logic [31:0] v);
    axw(4'h0, v, r);
    chk("ctrl write resp", {30'h0, sdprb_pkg::RESP_OKAY}, {30'h0, r});
    axr(4'h0, d, r);
    chk("ctrl readback", v, d);
  endtask
  task automatic mw(input logic [8:0] a, input logic [17:0] v);
    u_sdprb_fabric.access(1'b1, a, v, 1'b0, 9'h000);
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic mr(input logic [8:0] a, input logic [17:0] v);
    u_sdprb_fabric.access(1'b0, 9'h000, 18'h00000, 1'b1, a);
    repeat (6) @(posedge ref_clk);
    chk("read word", {14'h0, v}, {14'h0, rd_data});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    chk("rd_data at reset", 32'h0, {14'h0, rd_data});
    axr(4'h0, d, r);
    chk("ctrl at reset", sdprb_pkg::CTRL_RST, d);
    axr(4'h4, d, r);
    chk("status at reset", 32'h0002_0000, d);
    axr(4'h8, d, r);
    chk("unmapped resp", {30'h0, sdprb_pkg::RESP_SLVERR}, {30'h0, r});
    mr(9'h000, 18'h00001);
    mr(9'h002, 18'h00000);
    for (int s = 0; s < 7; s++) begin
      setc(ctl(3'h0, 3'(s), 4'h0));
      mw(9'(dep[s] - 1), 18'h3ffff);
      mr(9'(dep[s] - 1), 18'((1 << wid[s]) - 1));
    end
    // the top nine bits only exist as parity in the wide shapes
    setc(ctl(3'h0, 3'h4, 4'h0));
    mw(9'h03f, 18'h000a5);
    setc(ctl(3'h0, 3'h6, 4'h0));
    mr(9'h01f, 18'h14bff);
    mw(9'h005, 18'h00011);
    u_sdprb_fabric.access(1'b1, 9'h005, 18'h2aaaa, 1'b1, 9'h005);
    repeat (2) @(posedge ref_clk);
    chk("read during write", 32'h00011, {14'h0, rd_data});
    mr(9'h005, 18'h2aaaa);
    setc(ctl(3'h3, 3'h6, 4'h0));
    mw(9'h005, 18'h12345);
    mr(9'h005, 18'h2aaaa);
    setc(ctl(3'h1, 3'h6, 4'h0));
    u_sdprb_fabric.access(1'b0, 9'h000, 18'h0, 1'b1, 9'h005);
    repeat (6) @(posedge ref_clk);
    chk("single port read", 32'h2c3c3, {14'h0, rd_data});
    setc(ctl(3'h2, 3'h6, 4'h0));
    mw(9'h000, 18'h00101);
    mw(9'h000, 18'h00202);
    axr(4'h4, d, r);
    chk("fifo fill", 32'h2, d);
    mr(9'h000, 18'h00101);
    mr(9'h000, 18'h00202);
    mr(9'h000, 18'h00202);
    axr(4'h4, d, r);
    chk("fifo empty", 32'h0002_0000, d);
    repeat (33) mw(9'h000, 18'h00003);
    axr(4'h4, d, r);
    chk("fifo full", 32'h0001_0020, d);
    setc(ctl(3'h4, 3'h6, 4'h0));
    // shift writes at the pointer and reads the entry at it too, not rd_addr
    mw(9'h000, 18'h00777);
    mr(9'h002, 18'h00003);
    setc(ctl(3'h0, 3'h6, 4'h9));
    mw(9'h000, 18'h00abc);
    mw(9'h009, 18'h0f0f0);
    u_sdprb_fabric.access(1'b0, 9'h000, 18'h0, 1'b1, 9'h009);
    tick_on <= 2'h2;
    repeat (2) @(posedge ref_clk);
    chk("bypass read", 32'h0f0f0, {14'h0, rd_data});
    mw(9'h009, 18'h01234);
    chk("bypass follows array", 32'h01234, {14'h0, rd_data});
    cen <= 2'h1;
    mw(9'h009, 18'h3ffff);
    chk("write clock gated", 32'h01234, {14'h0, rd_data});
    cen <= 2'h3;
    in_clr <= 1'b1;
    #1;
    chk("input clear at once", 32'h01234, {14'h0, rd_data});
    repeat (2) @(posedge ref_clk);
    chk("input clear next edge", 32'h00abc, {14'h0, rd_data});
    in_clr <= 1'b0;
    tick_on <= 2'h3;
    setc(ctl(3'h0, 3'h6, 4'h4));
    slow <= 1'b1;
    mr(9'h009, 18'h01234);
    out_clr <= 1'b1;
    #1;
    chk("output clear", 32'h0, {14'h0, rd_data});
    @(posedge ref_clk);
    out_clr <= 1'b0;
    slow <= 1'b0;
    mr(9'h000, 18'h00abc);
    end_sim();
  end
endmodule
`default_nettype wire
